// >>> hdl/sdp_map.svh
// named constants for the single-wire debug command port
`ifndef SDP_MAP_SVH
`define SDP_MAP_SVH

// hardware command opcodes
`define SDP_OPC_BACKGROUND 8'h90
`define SDP_OPC_RD_DBG_BYTE 8'hE4
`define SDP_OPC_RD_DBG_WORD 8'hEC
`define SDP_OPC_WR_DBG_BYTE 8'hC4
`define SDP_OPC_WR_DBG_WORD 8'hCC
`define SDP_OPC_RD_BYTE 8'hE0
`define SDP_OPC_RD_WORD 8'hE8
`define SDP_OPC_WR_BYTE 8'hC0
`define SDP_OPC_WR_WORD 8'hC8

// firmware command opcodes
`define SDP_OPC_FW_RD_FIRST 8'h62
`define SDP_OPC_FW_RD_LAST 8'h67
`define SDP_OPC_FW_WR_FIRST 8'h42
`define SDP_OPC_FW_WR_LAST 8'h47
`define SDP_OPC_RESUME 8'h08
`define SDP_OPC_STEP 8'h10
`define SDP_OPC_TAG_RESUME 8'h18
`define SDP_FW_SEL_BASE 3'h2

// field lengths in bits
`define SDP_OPC_BITS 5'h08
`define SDP_FIELD_BITS 5'h10

// bit cell timing, cycles after the perceived bit start
`define SDP_CYC_PULSE1 4'h7
`define SDP_CYC_SAMPLE 4'hA
`define SDP_CYC_LOW0 4'hD
`define SDP_CYC_END 4'hF

// bus stealing and link time-out, debug clock cycles
`define SDP_STEAL_WAIT_CYC 128
`define SDP_TIMEOUT_CYC 512

// debug resource windows while mapped in
`define SDP_ROM_LO 16'hFF20
`define SDP_ROM_HI 16'hFFFF
`define SDP_REG_LO 16'hFF00
`define SDP_REG_HI 16'hFF06

// byte enables for byte and word accesses
`define SDP_BE_WORD 2'h3
`define SDP_BE_LOW 2'h1
`define SDP_BE_HIGH 2'h2

`endif

// >>> hdl/sdp_pkg.sv
// types shared by the single-wire debug command port
package sdp_pkg;

  // command sequencer states
  typedef enum logic [2:0] {
    SDP_ST_OPC    = 3'b000,
    SDP_ST_DECODE = 3'b001,
    SDP_ST_ADDR   = 3'b010,
    SDP_ST_DIN    = 3'b011,
    SDP_ST_BUS    = 3'b100,
    SDP_ST_ACCESS = 3'b101,
    SDP_ST_FWWAIT = 3'b110,
    SDP_ST_DOUT   = 3'b111
  } sdp_state_t;

  // firmware register selection
  typedef enum logic [2:0] {
    SDP_FW_NEXT = 3'b000,
    SDP_FW_PC   = 3'b001,
    SDP_FW_D    = 3'b010,
    SDP_FW_X    = 3'b011,
    SDP_FW_Y    = 3'b100,
    SDP_FW_SP   = 3'b101
  } sdp_fw_sel_t;

endpackage

// >>> hdl/sdp_sync.sv
// two-stage synchroniser for an asynchronous level
`timescale 1ns/1ns
module sdp_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // level in and out
  input wire logic d,
  output logic q
);

  logic meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// >>> hdl/sdp_bit_cell.sv
// timing of one serial bit on the debug pin
`timescale 1ns/1ns
`include "sdp_map.svh"
module sdp_bit_cell (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // bit control
  input wire logic bit_start,
  input wire logic tx_mode,
  input wire logic tx_bit,
  input wire logic pin_s,
  // pin drive
  output logic pin_out,
  output logic pin_oe,
  // received bit
  output logic rx_valid,
  output logic rx_bit
);

  logic [3:0] cnt;
  logic active;
  logic send;
  logic value;

  // cycle counter; cnt equals cycles since the perceived start
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 4'h0;
      active <= 1'b0;
      send <= 1'b0;
      value <= 1'b0;
    end
    else if (bit_start)
    begin
      cnt <= 4'h1;
      active <= 1'b1;
      send <= tx_mode;
      value <= tx_bit;
    end
    else if (active)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == `SDP_CYC_END)
        active <= 1'b0;
    end
  end

  // pin drive; a new edge restarts the cell and drives low only when sending a zero
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_oe <= 1'b0;
      pin_out <= 1'b1;
    end
    else if (bit_start)
    begin
      pin_oe <= tx_mode & ~tx_bit;
      pin_out <= 1'b0;
    end
    else if (active && send && value)
    begin
      // host must be released by now, else the pulse fights it
      pin_oe <= (cnt == `SDP_CYC_PULSE1 - 4'h1);
      pin_out <= 1'b1;
    end
    else if (active && send)
    begin
      if (cnt == `SDP_CYC_LOW0)
      begin
        pin_out <= 1'b1;
      end
      else if (cnt == `SDP_CYC_LOW0 + 4'h1)
      begin
        pin_oe <= 1'b0;
        pin_out <= 1'b1;
      end
    end
    else
    begin
      pin_oe <= 1'b0;
      pin_out <= 1'b1;
    end
  end

  // host bits are sampled at a fixed point in the cell
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
    end
    else
    begin
      rx_valid <= active & ~send & (cnt == `SDP_CYC_SAMPLE);
      if (active && !send && cnt == `SDP_CYC_SAMPLE)
        rx_bit <= pin_s;
    end
  end

endmodule

// >>> hdl/sdp_port.sv
// single-wire debug command port, target side
`timescale 1ns/1ns
`include "sdp_map.svh"
// Functional notes
// - bit start seen one to two cycles late
// - logic one: high pulse at cycle seven
// - logic zero: low thirteen cycles, then high
// - hardware commands steal cycle after 128
// - background opcode halts only if enabled
// - debug-space reads map debug resources briefly
// - debug-space writes map debug resources briefly
// - normal reads leave debug resources unmapped unless halted
// - normal writes leave debug resources unmapped unless halted
// - byte lanes by address parity, words aligned
// - firmware commands only while halted; fixed windows
// - firmware reads: next word or registers
// - firmware writes: next word or registers
// - resume, single step, tag and resume
// - opcode then optional address and data
// - every read returns sixteen bits
// - most significant bit first, sixteen cycles
// - 512 idle cycles clear the command
// - host bits sampled ten cycles after start
module sdp_port
  import sdp_pkg::*;
#(
  parameter int STEAL_WAIT = `SDP_STEAL_WAIT_CYC,
  parameter int TIMEOUT = `SDP_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // debug pin, pseudo open drain
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // cpu status
  input wire logic fw_enable,
  input wire logic halted_debug_state,
  input wire logic bus_idle,
  // cpu control
  output logic halt_req,
  output logic resume_req,
  output logic step_req,
  output logic tag_req,
  output logic cpu_freeze,
  // memory access
  output logic mem_stb,
  output logic mem_we,
  output logic mem_word,
  output logic [15:0] mem_addr,
  output logic [1:0] mem_be,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  output logic debug_map,
  output logic dbg_rom_sel,
  output logic dbg_reg_sel,
  // firmware hand-off
  output logic fw_req,
  output logic fw_write,
  output sdp_fw_sel_t fw_sel,
  output logic [15:0] fw_wdata,
  input wire logic fw_rdata_valid,
  input wire logic [15:0] fw_rdata,
  // link status
  output logic timeout_evt
);

  localparam int SW = $clog2(STEAL_WAIT + 1);
  localparam int TW = $clog2(TIMEOUT + 1);

  sdp_state_t state;
  sdp_state_t next_state;
  logic pin_s;
  logic pin_d;
  logic bit_start;
  logic rx_valid;
  logic rx_bit;
  logic tx_mode;
  logic [15:0] shreg;
  logic [15:0] next_word;
  logic [4:0] bit_cnt;
  logic [7:0] cmd;
  logic [SW-1:0] steal_cnt;
  logic [TW-1:0] tmo_cnt;
  logic tmo_hit;
  logic mem_dbg;
  logic grant;
  logic opc_done;
  logic addr_done;
  logic din_done;
  logic dout_done;
  // decoded command attributes
  logic cmd_mem;
  logic cmd_rd;
  logic cmd_word;
  logic cmd_dbg;
  logic cmd_bg;
  logic cmd_fw_rd;
  logic cmd_fw_wr;
  logic cmd_go;
  logic cmd_step;
  logic cmd_tag;

  // the pin is asynchronous to mclk; bit timing counts from here
  sdp_sync #(
    .RESET_VAL(1'b1)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(pin_in),
    .q(pin_s)
  );

  // falling edge of the synchronised pin marks the bit start
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pin_d <= 1'b1;
    else
      pin_d <= pin_s;
  end

  // a low shorter than one cycle may slip past the sampler
  assign bit_start = pin_d & ~pin_s;

  assign tx_mode = (state == SDP_ST_DOUT);

  // one bit cell handles both directions of the wire
  sdp_bit_cell u_cell (
    .mclk(mclk),
    .rst_b(rst_b),
    .bit_start(bit_start),
    .tx_mode(tx_mode),
    .tx_bit(shreg[15]),
    .pin_s(pin_s),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .rx_valid(rx_valid),
    .rx_bit(rx_bit)
  );

  // opcode decode; unknown codes fall back to waiting for an opcode
  always_comb
  begin
    cmd_mem = 1'b0;
    cmd_rd = 1'b0;
    cmd_word = 1'b0;
    cmd_dbg = 1'b0;
    cmd_bg = 1'b0;
    cmd_go = 1'b0;
    cmd_step = 1'b0;
    cmd_tag = 1'b0;
    cmd_fw_rd = (cmd >= `SDP_OPC_FW_RD_FIRST) &&
                (cmd <= `SDP_OPC_FW_RD_LAST);
    cmd_fw_wr = (cmd >= `SDP_OPC_FW_WR_FIRST) &&
                (cmd <= `SDP_OPC_FW_WR_LAST);
    case (cmd)
      `SDP_OPC_BACKGROUND: cmd_bg = 1'b1;
      `SDP_OPC_RD_DBG_BYTE:
      begin
        cmd_mem = 1'b1;
        cmd_rd = 1'b1;
        cmd_dbg = 1'b1;
      end
      `SDP_OPC_RD_DBG_WORD:
      begin
        cmd_mem = 1'b1;
        cmd_rd = 1'b1;
        cmd_word = 1'b1;
        cmd_dbg = 1'b1;
      end
      `SDP_OPC_WR_DBG_BYTE:
      begin
        cmd_mem = 1'b1;
        cmd_dbg = 1'b1;
      end
      `SDP_OPC_WR_DBG_WORD:
      begin
        cmd_mem = 1'b1;
        cmd_word = 1'b1;
        cmd_dbg = 1'b1;
      end
      `SDP_OPC_RD_BYTE:
      begin
        cmd_mem = 1'b1;
        cmd_rd = 1'b1;
      end
      `SDP_OPC_RD_WORD:
      begin
        cmd_mem = 1'b1;
        cmd_rd = 1'b1;
        cmd_word = 1'b1;
      end
      `SDP_OPC_WR_BYTE: cmd_mem = 1'b1;
      `SDP_OPC_WR_WORD:
      begin
        cmd_mem = 1'b1;
        cmd_word = 1'b1;
      end
      `SDP_OPC_RESUME: cmd_go = 1'b1;
      `SDP_OPC_STEP: cmd_step = 1'b1;
      `SDP_OPC_TAG_RESUME: cmd_tag = 1'b1;
      default: cmd_bg = 1'b0;
    endcase
  end

  // field completion strobes
  assign opc_done = rx_valid && state == SDP_ST_OPC &&
                    bit_cnt == `SDP_OPC_BITS - 5'h01;
  assign addr_done = rx_valid && state == SDP_ST_ADDR &&
                     bit_cnt == `SDP_FIELD_BITS - 5'h01;
  assign din_done = rx_valid && state == SDP_ST_DIN &&
                    bit_cnt == `SDP_FIELD_BITS - 5'h01;
  assign dout_done = bit_start && state == SDP_ST_DOUT &&
                     bit_cnt == `SDP_FIELD_BITS - 5'h01;
  assign next_word = {shreg[14:0], rx_bit};

  // a free bus cycle is used, or the frozen cpu gives one up
  assign grant = (state == SDP_ST_BUS) && (bus_idle || cpu_freeze);

  // link time-out: idle cycles since the last host edge
  assign tmo_hit = (tmo_cnt == TW'(TIMEOUT - 1));

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      tmo_cnt <= '0;
    else if (bit_start)
      tmo_cnt <= '0;
    else if (tmo_cnt != TW'(TIMEOUT))
      tmo_cnt <= tmo_cnt + TW'(1);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      timeout_evt <= 1'b0;
    else
      timeout_evt <= tmo_hit;
  end

  // sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      SDP_ST_OPC:
        if (opc_done)
          next_state = SDP_ST_DECODE;
      SDP_ST_DECODE:
        if (cmd_mem)
          next_state = SDP_ST_ADDR;
        else if (cmd_fw_rd && halted_debug_state)
          next_state = SDP_ST_FWWAIT;
        else if (cmd_fw_wr && halted_debug_state)
          next_state = SDP_ST_DIN;
        else
          next_state = SDP_ST_OPC;
      SDP_ST_ADDR:
        if (addr_done)
          next_state = cmd_rd ? SDP_ST_BUS : SDP_ST_DIN;
      SDP_ST_DIN:
        if (din_done)
          next_state = cmd_mem ? SDP_ST_BUS : SDP_ST_OPC;
      SDP_ST_BUS:
        if (grant)
          next_state = SDP_ST_ACCESS;
      SDP_ST_ACCESS:
        next_state = cmd_rd ? SDP_ST_DOUT : SDP_ST_OPC;
      SDP_ST_FWWAIT:
        if (fw_rdata_valid)
          next_state = SDP_ST_DOUT;
      SDP_ST_DOUT:
        if (dout_done)
          next_state = SDP_ST_OPC;
      default: next_state = SDP_ST_OPC;
    endcase
  end

  // state register; a time-out drops any half-received command
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      state <= SDP_ST_OPC;
    else if (tmo_hit)
      state <= SDP_ST_OPC;
    else
      state <= next_state;
  end

  // bit counter within the current field
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      bit_cnt <= 5'h00;
    else if (tmo_hit || next_state != state)
      bit_cnt <= 5'h00;
    else if (rx_valid && (state == SDP_ST_OPC ||
             state == SDP_ST_ADDR || state == SDP_ST_DIN))
      bit_cnt <= bit_cnt + 5'h01;
    else if (bit_start && state == SDP_ST_DOUT)
      bit_cnt <= bit_cnt + 5'h01;
  end

  // command register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cmd <= 8'h00;
    else if (tmo_hit)
      cmd <= 8'h00;
    else if (opc_done)
      cmd <= next_word[7:0];
  end

  // shift register: in, loaded from memory or firmware, out
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      shreg <= 16'h0000;
    else if (rx_valid && (state == SDP_ST_OPC ||
             state == SDP_ST_ADDR || state == SDP_ST_DIN))
      shreg <= next_word;
    else if (state == SDP_ST_ACCESS && cmd_rd)
    begin
      // unrequested byte lane reads as zero
      if (mem_word)
        shreg <= mem_rdata;
      else if (mem_addr[0])
        shreg <= {8'h00, mem_rdata[7:0]};
      else
        shreg <= {mem_rdata[15:8], 8'h00};
    end
    else if (state == SDP_ST_FWWAIT && fw_rdata_valid)
      shreg <= fw_rdata;
    else if (bit_start && state == SDP_ST_DOUT)
      shreg <= {shreg[14:0], 1'b0};
  end

  // address, data and lanes held for the memory access
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      mem_be <= `SDP_BE_WORD;
      mem_we <= 1'b0;
      mem_word <= 1'b0;
      mem_dbg <= 1'b0;
    end
    else if (addr_done)
    begin
      // word commands rely on the host sending aligned addresses
      mem_addr <= next_word;
      mem_we <= ~cmd_rd;
      mem_word <= cmd_word;
      mem_dbg <= cmd_dbg;
      if (cmd_word)
        mem_be <= `SDP_BE_WORD;
      else if (next_word[0])
        mem_be <= `SDP_BE_LOW;
      else
        mem_be <= `SDP_BE_HIGH;
    end
    else if (din_done && cmd_mem)
      mem_wdata <= next_word;
  end

  // steal counter and cpu freeze while a bus cycle is wanted
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      steal_cnt <= '0;
      cpu_freeze <= 1'b0;
    end
    else if (tmo_hit || state != SDP_ST_BUS)
    begin
      steal_cnt <= '0;
      // freeze spans the granting cycle and the stolen access cycle
      cpu_freeze <= 1'b0;
    end
    else if (!bus_idle && !cpu_freeze)
    begin
      steal_cnt <= steal_cnt + SW'(1);
      if (steal_cnt == SW'(STEAL_WAIT - 1))
        cpu_freeze <= 1'b1;
    end
  end

  // one-cycle memory strobe in the access state
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      mem_stb <= 1'b0;
    else
      mem_stb <= grant & ~tmo_hit;
  end

  // debug resources: always while halted, else just for a debug-space access
  assign debug_map = halted_debug_state | (mem_stb & mem_dbg);
  assign dbg_rom_sel = debug_map && mem_addr >= `SDP_ROM_LO &&
                       mem_addr <= `SDP_ROM_HI;
  assign dbg_reg_sel = debug_map && mem_addr >= `SDP_REG_LO &&
                       mem_addr <= `SDP_REG_HI;

  // firmware hand-off requests
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fw_req <= 1'b0;
      fw_write <= 1'b0;
      fw_sel <= SDP_FW_NEXT;
      fw_wdata <= 16'h0000;
    end
    else if (state == SDP_ST_DECODE && cmd_fw_rd && halted_debug_state)
    begin
      fw_req <= 1'b1;
      fw_write <= 1'b0;
      fw_sel <= sdp_fw_sel_t'(cmd[2:0] - `SDP_FW_SEL_BASE);
    end
    else if (din_done && !cmd_mem && !tmo_hit)
    begin
      fw_req <= 1'b1;
      fw_write <= 1'b1;
      fw_sel <= sdp_fw_sel_t'(cmd[2:0] - `SDP_FW_SEL_BASE);
      fw_wdata <= next_word;
    end
    else
      fw_req <= 1'b0;
  end

  // cpu run control pulses, issued from the decode cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      halt_req <= 1'b0;
      resume_req <= 1'b0;
      step_req <= 1'b0;
      tag_req <= 1'b0;
    end
    else
    begin
      halt_req <= state == SDP_ST_DECODE && cmd_bg && fw_enable;
      resume_req <= state == SDP_ST_DECODE && halted_debug_state &&
                    (cmd_go || cmd_tag);
      step_req <= state == SDP_ST_DECODE && halted_debug_state &&
                  cmd_step;
      tag_req <= state == SDP_ST_DECODE && halted_debug_state &&
                 cmd_tag;
    end
  end

endmodule

// >>> bench/sdp_host_model.sv
// host model driving the single-wire debug pin
`timescale 1ns/1ns
module sdp_host_model (
  // clock
  input wire logic mclk,
  // debug pin
  input wire logic pin,
  output logic host_low
);
  initial host_low = 1'b0;
  // one bit to the target; a one is released well before cycle ten
  task automatic tx_bit(input logic b);
    host_low <= 1'b1;
    repeat (b ? 3 : 16) @(negedge mclk);
    host_low <= 1'b0;
    repeat (b ? 17 : 4) @(negedge mclk);
  endtask
  // one bit from the target; held low long enough to overlap its drive
  task automatic rx_bit(output logic b);
    host_low <= 1'b1;
    repeat (6) @(negedge mclk);
    host_low <= 1'b0;
    repeat (4) @(negedge mclk);
    b = pin;
    repeat (10) @(negedge mclk);
  endtask
  // fields go out most significant bit first
  task automatic tx_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) tx_bit(v[i]);
  endtask
  task automatic tx_word(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) tx_bit(v[i]);
  endtask
  task automatic rx_word(output logic [15:0] v);
    for (int i = 15; i >= 0; i--) rx_bit(v[i]);
  endtask
endmodule

// >>> bench/sdp_port_assertions.sv
// concurrent checks on the debug command port pins
`timescale 1ns/1ns
module sdp_port_assertions #(
  parameter int TIMEOUT = 512
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // debug pin
  input wire logic pin_in,
  input wire logic pin_out,
  input wire logic pin_oe,
  // cpu and memory side
  input wire logic fw_enable,
  input wire logic halted_debug_state,
  input wire logic halt_req,
  input wire logic resume_req,
  input wire logic step_req,
  input wire logic tag_req,
  input wire logic cpu_freeze,
  input wire logic mem_stb,
  input wire logic mem_word,
  input wire logic [15:0] mem_addr,
  input wire logic [1:0] mem_be,
  input wire logic debug_map,
  input wire logic dbg_rom_sel,
  input wire logic fw_req,
  input wire logic timeout_evt
);
  logic pin_q;
  logic [9:0] since;
  logic [4:0] lo_run;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // cycles since raw pin first seen low; own drive is overlapped by host
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_q <= 1'b1;
      since <= 10'h000;
      lo_run <= 5'h00;
    end
    else
    begin
      pin_q <= pin_in;
      lo_run <= (pin_oe && !pin_out) ? lo_run + 5'h01 : 5'h00;
      if (!pin_in && pin_q)
        since <= 10'h000;
      else if (since != 10'h3FF)
        since <= since + 10'h001;
    end
  end
  property p_zero_len; pin_oe && pin_out && $past(pin_oe && !pin_out)
    |-> lo_run == 5'h0D; endproperty
  a_zero_len: assert property (p_zero_len)
    else $error("zero drive not thirteen cycles");
  property p_brief; pin_oe && pin_out |=> !pin_oe; endproperty
  a_brief: assert property (p_brief)
    else $error("high pulse longer than one cycle");
  property p_one_at; $rose(pin_oe) && pin_out
    |-> since == 10'h008; endproperty
  a_one_at: assert property (p_one_at)
    else $error("one pulse off cycle seven");
  property p_zero_at; $rose(pin_oe) && !pin_out
    |-> since == 10'h002; endproperty
  a_zero_at: assert property (p_zero_at)
    else $error("zero drive start misplaced");
  property p_halt; halt_req |-> fw_enable; endproperty
  a_halt: assert property (p_halt)
    else $error("halt without enable");
  property p_run; resume_req || step_req || tag_req
    |-> halted_debug_state && (resume_req || !tag_req); endproperty
  a_run: assert property (p_run)
    else $error("run request while not halted");
  property p_fw; fw_req |-> halted_debug_state; endproperty
  a_fw: assert property (p_fw)
    else $error("firmware request while not halted");
  property p_steal; $rose(cpu_freeze) |=> mem_stb ##1 !cpu_freeze;
  endproperty
  a_steal: assert property (p_steal)
    else $error("stolen cycle sequence wrong");
  property p_unmap; !mem_stb && !halted_debug_state |-> !debug_map;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("debug space mapped outside access");
  property p_rom; dbg_rom_sel == (debug_map && mem_addr >= 16'hFF20);
  endproperty
  a_rom: assert property (p_rom)
    else $error("rom select window wrong");
  property p_lane; mem_stb && !mem_word
    |-> mem_be == (mem_addr[0] ? 2'h1 : 2'h2); endproperty
  a_lane: assert property (p_lane)
    else $error("byte lane wrong");
  property p_tmo; timeout_evt
    |-> since >= TIMEOUT && since <= TIMEOUT + 8; endproperty
  a_tmo: assert property (p_tmo)
    else $error("time-out at wrong idle count");
endmodule
bind sdp_port sdp_port_assertions #(.TIMEOUT(TIMEOUT)) sdp_chk_i (
  .mclk(mclk), .rst_b(rst_b), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .fw_enable(fw_enable),
  .halted_debug_state(halted_debug_state), .halt_req(halt_req),
  .resume_req(resume_req), .step_req(step_req), .tag_req(tag_req),
  .cpu_freeze(cpu_freeze), .mem_stb(mem_stb), .mem_word(mem_word),
  .mem_addr(mem_addr), .mem_be(mem_be), .debug_map(debug_map),
  .dbg_rom_sel(dbg_rom_sel), .fw_req(fw_req), .timeout_evt(timeout_evt));

// >>> bench/testbench.sv
// self-checking bench for the debug command port
`timescale 1ns/1ns
module testbench;
  import sdp_pkg::*;
  localparam int SW = 8;
  localparam int TO = 64;
  localparam logic [7:0] OPS [8] = '{8'hE0, 8'hE8, 8'hE4, 8'hEC,
    8'hC0, 8'hC8, 8'hC4, 8'hCC};
  localparam logic [7:0] RUNS [4] = '{8'h08, 8'h10, 8'h18, 8'h08};
  logic mclk, rst_b, pin, host_low, pin_out, pin_oe, fw_enable, bus_idle;
  logic halted_debug_state, halt_req, resume_req, step_req, tag_req;
  logic cpu_freeze, mem_stb, mem_we, mem_word, debug_map, fw_req, fw_write;
  logic fw_rdata_valid, timeout_evt, dbg_cap, fww_cap, hv, reg_cap, reg_sel;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, fw_wdata, fw_rdata;
  logic [15:0] mem_val, fw_val, fwd_cap, a, d, r;
  logic [1:0] mem_be;
  logic [7:0] op, pv;
  sdp_fw_sel_t fw_sel, sel_cap;
  int failures = 0;
  int checks = 0;
  int cnt [8] = '{default: 0};
  int c0 [8];
  assign pin = host_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
  assign pv = {cpu_freeze, timeout_evt, mem_stb, fw_req,
    tag_req, step_req, resume_req, halt_req};
  sdp_host_model sdp_host_model_i (.mclk(mclk), .pin(pin),
    .host_low(host_low));
  sdp_port #(.STEAL_WAIT(SW), .TIMEOUT(TO)) sdp_port_i (.mclk(mclk),
    .rst_b(rst_b), .pin_in(pin), .pin_out(pin_out), .pin_oe(pin_oe),
    .fw_enable(fw_enable), .halted_debug_state(halted_debug_state),
    .bus_idle(bus_idle), .halt_req(halt_req), .resume_req(resume_req),
    .step_req(step_req), .tag_req(tag_req), .cpu_freeze(cpu_freeze),
    .mem_stb(mem_stb), .mem_we(mem_we), .mem_word(mem_word),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .debug_map(debug_map), .dbg_rom_sel(),
    .dbg_reg_sel(reg_sel), .fw_req(fw_req), .fw_write(fw_write),
    .fw_sel(fw_sel), .fw_wdata(fw_wdata), .fw_rdata_valid(fw_rdata_valid),
    .fw_rdata(fw_rdata), .timeout_evt(timeout_evt));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // pulse counts and captures of what the port hands out
  always @(posedge mclk)
  begin
    foreach (cnt[i]) cnt[i] += int'(pv[i]);
    if (mem_stb) {reg_cap, dbg_cap} <= {reg_sel, debug_map};
    if (fw_req) sel_cap <= fw_sel;
    if (fw_req) {fww_cap, fwd_cap} <= {fw_write, fw_wdata};
  end
  // far side answers; idle data inverted so stale values cannot pass
  always @(negedge mclk)
  begin
    mem_rdata <= mem_stb ? mem_val : ~mem_val;
    fw_rdata_valid <= fw_req & ~fw_write;
    fw_rdata <= fw_req ? fw_val : ~fw_val;
  end
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [15:0] dn(input int i);
    return 16'(cnt[i] - c0[i]);
  endfunction
  function automatic logic [15:0] exp_rd(input logic [7:0] o,
    input logic [15:0] ad, input logic [15:0] v);
    if (o[3]) return v;
    return ad[0] ? {8'h00, v[7:0]} : {v[15:8], 8'h00};
  endfunction
  // kind: 0 opcode only, 1 memory read, 2 memory write, 3 fw read, 4 fw write
  task automatic cmd(input logic [7:0] o, input logic [15:0] ad,
    input logic [15:0] dat, input int kind);
    r = 16'h0000;
    c0 = cnt;
    sdp_host_model_i.tx_byte(o);
    if (kind == 1 || kind == 2) sdp_host_model_i.tx_word(ad);
    if (kind == 2 || kind == 4) sdp_host_model_i.tx_word(dat);
    if (kind == 1) repeat (SW + 22) @(negedge mclk);
    if (kind == 3) repeat (32) @(negedge mclk);
    if (kind == 1 || kind == 3) sdp_host_model_i.rx_word(r);
    repeat (SW + 22) @(negedge mclk);
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge mclk);
    failures++;
    close_out();
  end
  initial
  begin
    rst_b = 1'b0;
    fw_enable = 1'b0;
    halted_debug_state = 1'b0;
    bus_idle = 1'b1;
    mem_rdata = 16'h0000;
    fw_rdata = 16'h0000;
    fw_rdata_valid = 1'b0;
    fw_val = 16'h0000;
    mem_val = 16'($urandom(32'h1AB6B914));
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    // memory commands: boundary addresses, random, then bus kept busy
    for (int p = 0; p < 3; p++)
      foreach (OPS[i])
      begin
        op = OPS[i];
        a = p == 0 ? (op[3] ? 16'hFF20 : 16'hFF01) : 16'($urandom);
        a[0] = a[0] & ~op[3];
        d = 16'($urandom);
        mem_val = 16'($urandom);
        bus_idle = p != 2;
        cmd(op, a, d, op[5] ? 1 : 2);
        chk("mem_addr", a, mem_addr);
        chk("mem_we", 16'(!op[5]), 16'(mem_we));
        chk("mem_word", 16'(op[3]), 16'(mem_word));
        chk("mem_be", op[3] ? 16'h3 : (a[0] ? 16'h1 : 16'h2), 16'(mem_be));
        chk("debug_map", 16'(op[2]), 16'(dbg_cap));
        hv = op[2] && a >= 16'hFF00 && a < 16'hFF07;
        chk("dbg_reg_sel", 16'(hv), 16'(reg_cap));
        chk("mem_stb", 16'h0001, dn(5));
        chk("cpu_freeze", 16'(p == 2), 16'(dn(7) != 16'h0));
        if (op[5]) chk("rd_data", exp_rd(op, a, mem_val), r);
        else chk("mem_wdata", d, mem_wdata);
      end
    bus_idle = 1'b1;
    $display("memory commands done");
    for (int e = 0; e < 2; e++)
    begin
      fw_enable = e[0];
      cmd(8'h90, 16'h0000, 16'h0000, 0);
      chk("halt_req", 16'(e), dn(0));
    end
    $display("halt command done");
    halted_debug_state = 1'b1;
    for (int k = 0; k < 12; k++)
    begin
      op = k < 6 ? 8'h62 + 8'(k) : 8'h42 + 8'(k - 6);
      fw_val = 16'($urandom);
      d = 16'($urandom);
      cmd(op, 16'h0000, d, k < 6 ? 3 : 4);
      chk("fw_req", 16'h0001, dn(4));
      chk("fw_sel", 16'(k % 6), 16'(sel_cap));
      chk("fw_write", 16'(k >= 6), 16'(fww_cap));
      if (k < 6) chk("fw_data", fw_val, r);
      else chk("fw_wdata", d, fwd_cap);
    end
    $display("firmware commands done");
    for (int k = 0; k < 5; k++)
    begin
      op = k < 4 ? RUNS[k] : 8'h63;
      hv = k < 3;
      halted_debug_state = hv;
      cmd(op, 16'h0000, 16'h0000, 0);
      chk("resume_req", 16'(hv && op != 8'h10), dn(1));
      chk("step_req", 16'(hv && op == 8'h10), dn(2));
      chk("tag_req", 16'(hv && op == 8'h18), dn(3));
      chk("fw_req", 16'h0000, dn(4));
    end
    $display("run commands done");
    // half an opcode, then silence until the link gives up
    c0 = cnt;
    for (int k = 7; k > 3; k--) sdp_host_model_i.tx_bit(OPS[1][k]);
    repeat (TO + 20) @(negedge mclk);
    chk("timeout_evt", 16'h0001, dn(6));
    mem_val = 16'($urandom);
    cmd(8'hE8, 16'h1234, 16'h0000, 1);
    chk("rd_after_timeout", mem_val, r);
    $display("time-out done");
    close_out();
  end
endmodule
